//--- test/eis_tb.sv
`timescale 1ns/1ps
module testbench;
    import eis_pkg::*;

    // Clock, reset and design ports
    logic clk;
    logic nrst;
    eis_bus_s bus;
    logic [31:0] rd_data;
    eis_events_s ev;
    logic master_irq;
    logic power_irq;
    logic low_power;
    // Result counters
    int n_errors;
    int check_count;
    // Expected status bit per source case, -1 when the case must set nothing
    int exp_bit [26] = '{14, 13, 16, 6, 20, 17, 0, 1, 2, 25, -1, 24, 21, -1, 10, -1,
                         15, -1, 9, -1, 8, 7, 4, 3, 23, 19};
    logic [31:0] exp_v;

    eis_top uut (
        .clk(clk),
        .nrst(nrst),
        .bus(bus),
        .rd_data(rd_data),
        .ev(ev),
        .master_irq(master_irq),
        .power_irq(power_irq),
        .low_power(low_power)
    );

    // Free-running 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Quiet source inputs; the timer rests at its wrap value
    function automatic eis_events_s idle_ev();
        eis_events_s e;
        e = '0;
        e.timer_count = TIMER_TO;
        return e;
    endfunction

    // Compare one value and count the outcome
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    // One-cycle read strobe, data taken in the following cycle only
    task automatic rdchk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        chk(name, rd_data, exp);
    endtask

    // Drive one source condition on, or back to quiet
    task automatic stim(input int k, input bit on);
        eis_events_s e;
        e = idle_ev();
        e.drop_count = (k == 24) ? DROP_MID_AFTER : ev.drop_count;
        if (on) begin
            case (k)
                0: e.rx_fault = 1'b1;
                1: e.tx_fault = 1'b1;
                2: e.tx_status_lost = 1'b1;
                3: e.frame_dropped = 1'b1;
                4: e.rx_count_done = 1'b1;
                5: e.power_event = 1'b1;
                6: e.pin_events = 3'h1;
                7: e.pin_events = 3'h2;
                8: e.pin_events = 3'h4;
                9: e = '{default: 0, tx_halt_req: 1'b1, tx_halted: 1'b1,
                         timer_count: TIMER_TO, drop_count: ev.drop_count};
                10: e.tx_halted = 1'b1;
                11: e.rx_halted = 1'b1;
                12: e = '{default: 0, buffer_loaded: 1'b1, completion_notify_mark: 1'b1,
                          timer_count: TIMER_TO, drop_count: ev.drop_count};
                13: e.buffer_loaded = 1'b1;
                14: e = '{default: 0, tx_data_write: 1'b1, tx_data_full: 1'b1,
                          timer_count: TIMER_TO, drop_count: ev.drop_count};
                15: e.tx_data_write = 1'b1;
                16: e = '{default: 0, frame_done: 1'b1, frame_len: 16'h0801,
                          timer_count: TIMER_TO, drop_count: ev.drop_count};
                17: e = '{default: 0, frame_done: 1'b1, frame_len: FRAME_LEN_MAX,
                          timer_count: TIMER_TO, drop_count: ev.drop_count};
                18: e = '{default: 0, tx_free_blocks: 8'h05, tx_space_level: 8'h04,
                          timer_count: TIMER_TO, drop_count: ev.drop_count};
                19: e = '{default: 0, tx_free_blocks: 8'h04, tx_space_level: 8'h04,
                          timer_count: TIMER_TO, drop_count: ev.drop_count};
                20: e.tx_status_full = 1'b1;
                21: e = '{default: 0, tx_status_used: 8'h03, tx_status_level: 8'h02,
                          timer_count: TIMER_TO, drop_count: ev.drop_count};
                22: e.rx_status_full = 1'b1;
                23: e = '{default: 0, rx_status_used: 8'h03, rx_status_level: 8'h02,
                          timer_count: TIMER_TO, drop_count: ev.drop_count};
                24: e.drop_count = DROP_MID_BEFORE;
                25: e.timer_count = TIMER_FROM;
                default: ;
            endcase
        end
        ev <= e;
    endtask

    // One-cycle source event, then time for flag and interrupt lines to settle
    task automatic pulse(input int k);
        @(posedge clk);
        stim(k, 1'b1);
        @(posedge clk);
        stim(k, 1'b0);
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Counts, verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Guard against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("[FAIL] run_time expected end seen timeout");
        tally_and_finish();
    end

    // Main sequence
    initial begin
        n_errors = 0;
        check_count = 0;
        nrst = 1'b0;
        bus = '0;
        ev = idle_ev();
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        // Reset values, constant register and an unmapped place
        rdchk("status_reset", STS_OFS, STS_RESET);
        rdchk("enable_reset", EN_OFS, EN_RESET);
        rdchk("byte_test", BYTE_TEST_OFS, BYTE_TEST_VAL);
        // Read data stands one cycle only, then returns to zero
        @(negedge clk);
        chk("rd_idle", rd_data, 32'h0);
        rdchk("unmapped", 8'h70, 32'h0);
        // Enable readback and sticky software flag
        wr(EN_OFS, 32'hffffffff);
        rdchk("enable_rw", EN_OFS, 32'hffffffff);
        rdchk("sw_set", STS_OFS, 32'h80000000);
        chk("master_sw", {31'h0, master_irq}, 32'h1);
        wr(EN_OFS, 32'h0);
        rdchk("sw_sticky", STS_OFS, 32'h80000000);
        wr(STS_OFS, 32'hffffffff);
        rdchk("sw_clear", STS_OFS, 32'h0);
        // Every source except the software and transceiver flags, and near-miss conditions, with all enables off
        for (int k = 0; k < 26; k++) begin
            exp_v = (exp_bit[k] < 0) ? 32'h0 : (32'h1 << exp_bit[k]);
            pulse(k);
            rdchk("src_set", STS_OFS, exp_v);
            chk("master_masked", {31'h0, master_irq}, 32'h0);
            wr(STS_OFS, 32'h0);
            rdchk("write_zero", STS_OFS, exp_v);
            wr(STS_OFS, exp_v);
            rdchk("write_one", STS_OFS, 32'h0);
        end
        // Master line follows only enabled flags
        wr(EN_OFS, 32'h00004000);
        pulse(1);
        chk("master_other", {31'h0, master_irq}, 32'h0);
        wr(STS_OFS, 32'hffffffff);
        pulse(0);
        chk("master_on", {31'h0, master_irq}, 32'h1);
        wr(STS_OFS, 32'h00004000);
        repeat (2) @(posedge clk);
        #1;
        chk("master_off", {31'h0, master_irq}, 32'h0);
        // Power event line without hold-off, and sleep until byte-test write
        wr(EN_OFS, 32'h00020000);
        @(posedge clk);
        ev.sleep_req <= 1'b1;
        @(posedge clk);
        ev.sleep_req <= 1'b0;
        pulse(5);
        chk("power_irq", {31'h0, power_irq}, 32'h1);
        chk("still_asleep", {31'h0, low_power}, 32'h1);
        wr(EN_OFS, 32'h0);
        @(negedge clk);
        chk("asleep_other_wr", {31'h0, low_power}, 32'h1);
        wr(BYTE_TEST_OFS, 32'h0);
        @(negedge clk);
        chk("woken", {31'h0, low_power}, 32'h0);
        chk("power_masked", {31'h0, power_irq}, 32'h0);
        rdchk("byte_test_kept", BYTE_TEST_OFS, BYTE_TEST_VAL);
        wr(STS_OFS, 32'h00020000);
        rdchk("power_clear", STS_OFS, 32'h0);
        // Transceiver flag mirrors its input and ignores writes
        @(posedge clk);
        ev.phy_event <= 1'b1;
        repeat (2) @(posedge clk);
        rdchk("phy_on", STS_OFS, 32'h00040000);
        wr(STS_OFS, 32'hffffffff);
        rdchk("phy_kept", STS_OFS, 32'h00040000);
        @(posedge clk);
        ev.phy_event <= 1'b0;
        repeat (2) @(posedge clk);
        rdchk("phy_off", STS_OFS, 32'h0);
        tally_and_finish();
    end
endmodule

//--- verilog/eis_pkg.sv
package eis_pkg;

    // Register offsets, byte addresses on the register port
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] STS_OFS = 8'h58;
    localparam logic [ADDR_W-1:0] EN_OFS = 8'h5c;
    localparam logic [ADDR_W-1:0] BYTE_TEST_OFS = 8'h64;

    // Status flag positions
    localparam int BIT_SW = 31;
    localparam int BIT_TX_HALT = 25;
    localparam int BIT_RX_HALT = 24;
    localparam int BIT_DROP_MID = 23;
    localparam int BIT_BUF_LOADED = 21;
    localparam int BIT_RX_COUNT = 20;
    localparam int BIT_TIMER = 19;
    localparam int BIT_PHY = 18;
    localparam int BIT_POWER = 17;
    localparam int BIT_TXS_OVF = 16;
    localparam int BIT_OVERSIZE = 15;
    localparam int BIT_RX_FAULT = 14;
    localparam int BIT_TX_FAULT = 13;
    localparam int BIT_TXD_OVR = 10;
    localparam int BIT_TX_SPACE = 9;
    localparam int BIT_TXS_FULL = 8;
    localparam int BIT_TXS_LEVEL = 7;
    localparam int BIT_DROPPED = 6;
    localparam int BIT_RXS_FULL = 4;
    localparam int BIT_RXS_LEVEL = 3;
    localparam int BIT_PIN_LO = 0;
    localparam int PIN_N = 3;

    // Implemented bits, clearable bits and reset values
    localparam logic [31:0] STS_IMPL_MASK = 32'h83bfe7df;
    localparam logic [31:0] STS_W1C_MASK = 32'h83bbe7df;
    localparam logic [31:0] STS_RESET = 32'h00000000;
    localparam logic [31:0] EN_RESET = 32'h00000000;
    localparam logic [31:0] BYTE_TEST_VAL = 32'h87654321;

    // Source thresholds and wrap points
    localparam int DROP_W = 28;
    localparam logic [DROP_W-1:0] DROP_MID_BEFORE = 28'h7ffffff;
    localparam logic [DROP_W-1:0] DROP_MID_AFTER = 28'h8000000;
    localparam logic [DROP_W-1:0] DROP_RESET = 28'h0000000;
    localparam int TIMER_W = 16;
    localparam logic [TIMER_W-1:0] TIMER_FROM = 16'h0000;
    localparam logic [TIMER_W-1:0] TIMER_TO = 16'hffff;
    localparam int LEN_W = 16;
    localparam logic [LEN_W-1:0] FRAME_LEN_MAX = 16'h0800;
    localparam int LVL_W = 8;

    // Power state
    typedef enum logic [1:0] {
        EIS_AWAKE = 2'b00,
        EIS_ASLEEP = 2'b01
    } eis_pwr_e;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } eis_bus_s;

    // Event and condition inputs from the source blocks
    typedef struct packed {
        logic tx_halt_req;
        logic tx_halted;
        logic rx_halted;
        logic [DROP_W-1:0] drop_count;
        logic buffer_loaded;
        logic completion_notify_mark;
        logic rx_count_done;
        logic [TIMER_W-1:0] timer_count;
        logic phy_event;
        logic power_event;
        logic tx_status_lost;
        logic frame_done;
        logic [LEN_W-1:0] frame_len;
        logic rx_fault;
        logic tx_fault;
        logic tx_data_write;
        logic tx_data_full;
        logic [LVL_W-1:0] tx_free_blocks;
        logic [LVL_W-1:0] tx_space_level;
        logic tx_status_full;
        logic [LVL_W-1:0] tx_status_used;
        logic [LVL_W-1:0] tx_status_level;
        logic rx_status_full;
        logic [LVL_W-1:0] rx_status_used;
        logic [LVL_W-1:0] rx_status_level;
        logic frame_dropped;
        logic [PIN_N-1:0] pin_events;
        logic sleep_req;
    } eis_events_s;

endpackage

//--- verilog/eis_top.sv
`timescale 1ns/1ps
// Behaviour
// R1 - Writing one clears flag, zero leaves it
// R2 - Software flag sets on enable, sticky
// R3 - Set when halt requested and transmitter halted
// R4 - Set when receive engine halted
// R5 - Set when drop counter crosses midpoint
// R6 - Set when notify-marked buffer fully loaded
// R7 - Set when receive transfer count drained
// R8 - Set when timer wraps zero to FFFFh
// R9 - Transceiver flag read-only, writes ignored
// R10 - Power event flag independent of wake pin
// R11 - Only byte test write wakes device
// R12 - Power flag bypasses deassertion hold-off
// R13 - Set when transmit status entry lost
// R14 - Set on frame longer than 2048 bytes
// R15 - Set on receive fault
// R16 - Set on transmit fault
// R17 - Set on write to full data FIFO
// R18 - Set when free space exceeds threshold
// R19 - Set when status FIFOs become full
// R20 - Set when status FIFO levels exceed threshold
// R21 - Set on each discarded received frame
// R22 - Pin event flags, write one clears
// R23 - Flags set regardless of enable mask
// R24 - Master line high on enabled pending flag
// R25 - Reserved bits read zero, writes ignored
module eis_top (
    input wire logic clk,
    input wire logic nrst,
    input wire eis_pkg::eis_bus_s bus,
    output logic [31:0] rd_data,
    input wire eis_pkg::eis_events_s ev,
    output logic master_irq,
    output logic power_irq,
    output logic low_power
);
    import eis_pkg::*;

    // Reset synchroniser stages
    logic rst_meta_ff;
    logic rst_n_ff;

    // Register state
    logic [31:0] sts_ff; // Status flags
    logic [31:0] nxt_sts;
    logic [31:0] en_ff; // Enable mask
    logic [31:0] nxt_en;
    logic [31:0] rdata_ff; // Read data, one cycle after strobe
    logic [31:0] nxt_rdata;
    logic sw_en_prev_ff; // Previous software enable bit
    logic nxt_sw_en_prev;
    logic [DROP_W-1:0] drop_prev_ff; // Previous drop count
    logic [DROP_W-1:0] nxt_drop_prev;
    logic [TIMER_W-1:0] timer_prev_ff; // Previous timer count
    logic [TIMER_W-1:0] nxt_timer_prev;
    logic master_ff; // Master interrupt line
    logic nxt_master;
    logic power_irq_ff; // Immediate power event line
    logic nxt_power_irq;
    eis_pwr_e pwr_ff; // Power state
    eis_pwr_e nxt_pwr;
    logic low_power_ff; // Registered copy of the sleep state for the pin
    logic nxt_low_power;

    // Decode and event vectors
    logic [31:0] set_vec; // Per-bit set requests
    logic [31:0] clr_vec; // Per-bit clear requests
    logic sts_wr; // Write to status register
    logic en_wr; // Write to enable register
    logic wake_wr; // Write to byte test register

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // Address decode
    assign sts_wr = bus.wr && (bus.addr == STS_OFS);
    assign en_wr = bus.wr && (bus.addr == EN_OFS);
    assign wake_wr = bus.wr && (bus.addr == BYTE_TEST_OFS);

    // Event collection, independent of the enable mask
    always_comb begin
        set_vec = 32'h00000000; // R23
        // Software flag on rising enable
        set_vec[BIT_SW] = en_ff[BIT_SW] && !sw_en_prev_ff; // R2
        set_vec[BIT_TX_HALT] = ev.tx_halt_req && ev.tx_halted; // R3
        set_vec[BIT_RX_HALT] = ev.rx_halted; // R4
        // Midpoint crossing of the drop counter
        set_vec[BIT_DROP_MID] = (drop_prev_ff == DROP_MID_BEFORE) &&
                                (ev.drop_count == DROP_MID_AFTER); // R5
        set_vec[BIT_BUF_LOADED] = ev.buffer_loaded && ev.completion_notify_mark; // R6
        set_vec[BIT_RX_COUNT] = ev.rx_count_done; // R7
        // Timer wrap past zero
        set_vec[BIT_TIMER] = (timer_prev_ff == TIMER_FROM) &&
                             (ev.timer_count == TIMER_TO); // R8
        set_vec[BIT_POWER] = ev.power_event; // R10
        set_vec[BIT_TXS_OVF] = ev.tx_status_lost; // R13
        set_vec[BIT_OVERSIZE] = ev.frame_done && (ev.frame_len > FRAME_LEN_MAX); // R14
        set_vec[BIT_RX_FAULT] = ev.rx_fault; // R15
        set_vec[BIT_TX_FAULT] = ev.tx_fault; // R16
        set_vec[BIT_TXD_OVR] = ev.tx_data_write && ev.tx_data_full; // R17
        set_vec[BIT_TX_SPACE] = ev.tx_free_blocks > ev.tx_space_level; // R18
        set_vec[BIT_TXS_FULL] = ev.tx_status_full; // R19
        set_vec[BIT_RXS_FULL] = ev.rx_status_full; // R19
        set_vec[BIT_TXS_LEVEL] = ev.tx_status_used > ev.tx_status_level; // R20
        set_vec[BIT_RXS_LEVEL] = ev.rx_status_used > ev.rx_status_level; // R20
        set_vec[BIT_DROPPED] = ev.frame_dropped; // R21
        set_vec[BIT_PIN_LO +: PIN_N] = ev.pin_events; // R22
        // Clear only clearable bits written with one
        clr_vec = sts_wr ? (bus.wdata & STS_W1C_MASK) : 32'h00000000; // R1
    end

    // Per-bit sticky flags except the transceiver mirror, set wins over clear
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_flag
            always_comb begin
                if (!STS_IMPL_MASK[gi]) begin
                    // Reserved position holds zero
                    nxt_sts[gi] = 1'b0; // R25
                end else if (gi == BIT_PHY) begin
                    // Live mirror, not writable
                    nxt_sts[gi] = ev.phy_event; // R9
                end else begin
                    nxt_sts[gi] = set_vec[gi] || (sts_ff[gi] && !clr_vec[gi]); // R1
                end
            end
        end
    endgenerate

    // Register side next values
    always_comb begin
        nxt_en = en_wr ? bus.wdata : en_ff;
        nxt_sw_en_prev = en_ff[BIT_SW];
        nxt_drop_prev = ev.drop_count;
        nxt_timer_prev = ev.timer_count;
        nxt_rdata = 32'h00000000;
        // Read mux, unmapped reads return zero
        if (bus.rd) begin
            case (bus.addr)
                STS_OFS: begin
                    nxt_rdata = sts_ff & STS_IMPL_MASK; // R25
                end
                EN_OFS: begin
                    nxt_rdata = en_ff;
                end
                BYTE_TEST_OFS: begin
                    nxt_rdata = BYTE_TEST_VAL;
                end
                default: begin
                    nxt_rdata = 32'h00000000;
                end
            endcase
        end
        // Master line from enabled pending flags
        nxt_master = |(sts_ff & en_ff & STS_IMPL_MASK); // R24
        // Power line bypasses any hold-off timer
        nxt_power_irq = sts_ff[BIT_POWER] && en_ff[BIT_POWER]; // R12
    end

    // Power state, only a byte test write wakes
    always_comb begin
        case (pwr_ff)
            EIS_AWAKE: begin
                nxt_pwr = (ev.sleep_req && !wake_wr) ? EIS_ASLEEP : EIS_AWAKE;
            end
            EIS_ASLEEP: begin
                // Power events do not wake
                nxt_pwr = wake_wr ? EIS_AWAKE : EIS_ASLEEP; // R11
            end
            default: begin
                nxt_pwr = EIS_AWAKE;
            end
        endcase
        // Output follows the next state so it lines up with pwr_ff
        nxt_low_power = (nxt_pwr == EIS_ASLEEP); // R11
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sts_ff <= STS_RESET;
            en_ff <= EN_RESET;
            rdata_ff <= 32'h00000000;
            sw_en_prev_ff <= 1'b0;
            drop_prev_ff <= DROP_RESET;
            timer_prev_ff <= TIMER_TO;
            master_ff <= 1'b0;
            power_irq_ff <= 1'b0;
            pwr_ff <= EIS_AWAKE;
            low_power_ff <= 1'b0;
        end else begin
            sts_ff <= nxt_sts;
            en_ff <= nxt_en;
            rdata_ff <= nxt_rdata;
            sw_en_prev_ff <= nxt_sw_en_prev;
            drop_prev_ff <= nxt_drop_prev;
            timer_prev_ff <= nxt_timer_prev;
            master_ff <= nxt_master;
            power_irq_ff <= nxt_power_irq;
            pwr_ff <= nxt_pwr;
            low_power_ff <= nxt_low_power;
        end
    end

    // Outputs from flip-flops
    assign rd_data = rdata_ff;
    assign master_irq = master_ff;
    assign power_irq = power_irq_ff;
    assign low_power = low_power_ff;

    // Checks
    w1c_clear_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R1
        (sts_wr && bus.wdata[BIT_RX_FAULT] && !ev.rx_fault) |=> !sts_ff[BIT_RX_FAULT])
        else $error("status bit not cleared by write of one");
    w0_keep_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R1
        (sts_wr && !bus.wdata[BIT_TX_FAULT] && sts_ff[BIT_TX_FAULT]) |=> sts_ff[BIT_TX_FAULT])
        else $error("status bit lost on write of zero");
    sw_flag_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R2
        (en_wr && bus.wdata[BIT_SW] && !en_ff[BIT_SW]) |-> ##2 sts_ff[BIT_SW])
        else $error("software flag not set after enable");
    tx_halt_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R3
        (ev.tx_halt_req && ev.tx_halted) |=> sts_ff[BIT_TX_HALT])
        else $error("transmit halted flag missing");
    drop_mid_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R5
        ($past(ev.drop_count) == DROP_MID_BEFORE && ev.drop_count == DROP_MID_AFTER)
        |=> sts_ff[BIT_DROP_MID])
        else $error("drop midpoint flag missing");
    timer_wrap_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R8
        (!$past(sts_ff[BIT_TIMER]) && sts_ff[BIT_TIMER]) |->
        ($past(timer_prev_ff) == TIMER_FROM && $past(ev.timer_count) == TIMER_TO))
        else $error("timer flag set without a wrap");
    phy_mirror_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R9
        ##1 sts_ff[BIT_PHY] == $past(ev.phy_event))
        else $error("transceiver flag does not follow its source");
    wake_only_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R11
        (low_power && !wake_wr) |=> low_power)
        else $error("woke without a byte test write");
    wake_write_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R11
        (low_power && wake_wr) |=> !low_power)
        else $error("byte test write did not wake");
    power_fast_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R12
        (ev.power_event && en_ff[BIT_POWER] && !en_wr) |-> ##2 power_irq)
        else $error("power line delayed");
    oversize_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R14
        (ev.frame_done && ev.frame_len == FRAME_LEN_MAX && !sts_ff[BIT_OVERSIZE])
        |=> !sts_ff[BIT_OVERSIZE])
        else $error("oversize flag on a 2048 byte frame");
    mask_free_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R23
        (ev.rx_fault && !en_ff[BIT_RX_FAULT]) |=> sts_ff[BIT_RX_FAULT])
        else $error("masked source did not set its flag");
    master_line_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R24
        ##1 master_irq == $past(|(sts_ff & en_ff & STS_IMPL_MASK)))
        else $error("master line disagrees with pending flags");
    reserved_a: assert property (@(posedge clk) disable iff (!rst_n_ff) // R25
        (bus.rd && bus.addr == STS_OFS) |=> ((rd_data & ~STS_IMPL_MASK) == 32'h00000000))
        else $error("reserved status bits read nonzero");

endmodule
